// ---- core/icr_pkg.sv ----
// Package for the interrupt controller register block.
// Assumes a single hclk domain and an AHB-Lite master in front of it.
package icr_pkg;

    // Source and vector counts
    localparam int NUM_SRC = 96;
    localparam int NUM_VEC = 64;
    localparam int NUM_EXT = 5;
    localparam int SRC_WORDS = 3;
    localparam int PRIO_WORDS = 16;
    localparam int VEC_PER_WORD = 4;

    // Address decode width, byte addresses
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 10'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h010;
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 10'h020;
    localparam logic [ADDR_W-1:0] OFF_PENDING = 10'h030;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 10'h060;
    localparam logic [ADDR_W-1:0] OFF_PRIO = 10'h090;
    localparam int GROUP_LSB = 4;

    // Alias selector, address bits 3:2
    localparam logic [1:0] OP_BASE = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;

    // Control register fields
    localparam int BIT_SHADOW = 16;
    localparam int BIT_HALT = 14;
    localparam int BIT_MULTI = 12;
    localparam int THR_LSB = 8;
    localparam int POL_LSB = 0;
    localparam logic [31:0] CTRL_MASK = 32'h0001_571F;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status register fields
    localparam int VEC_LSB = 0;
    localparam int LVL_LSB = 8;

    // Priority word layout: 3-bit level, 2-bit sub, 8-bit stride
    localparam int PRIO_STRIDE = 8;
    localparam logic [31:0] PRIO_MASK = 32'h1F1F_1F1F;
    localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;
    localparam logic [2:0] LVL_OFF = 3'h0;
    localparam logic [2:0] THR_OFF = 3'h0;

    // AHB transfer kind
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Offer presented to the core
    typedef struct packed {
        logic req;
        logic [2:0] level;
        logic [5:0] vector;
    } icr_offer_t;

    // Whole block state
    typedef struct packed {
        logic dp_write;
        logic [ADDR_W-1:0] dp_addr;
        logic [31:0] hrdata;
        logic hready;
        logic [31:0] control;
        logic [31:0] reload;
        logic [31:0] timer;
        logic prox_busy;
        logic [NUM_SRC-1:0] pending;
        logic [NUM_SRC-1:0] enable;
        logic [NUM_VEC-1:0][4:0] prio;
        logic [NUM_EXT-1:0] sync1;
        logic [NUM_EXT-1:0] sync2;
        logic [NUM_EXT-1:0] pin_prev;
        icr_offer_t offer;
        logic multi;
    } icr_state_t;

endpackage

// ---- core/icr_top.sv ----
// Interrupt controller: register file on AHB-Lite, source ranking,
// external pin edge detection, proximity timer and offer to the core.
// Assumes peripheral events and debug_mode come from hclk logic; the
// external pins are asynchronous and are synchronised here.
`timescale 1ns/10ps

module icr_top #(
    parameter int EXT_SRC_BASE = 0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [icr_pkg::NUM_SRC-1:0] src_event,
    input wire logic [icr_pkg::NUM_EXT-1:0] ext_pin,
    input wire logic debug_mode,
    output logic irq_req,
    output logic [2:0] irq_level,
    output logic [5:0] irq_vector,
    output logic irq_multi,
    output logic prox_busy
);

    // Present and next copy of all state
    icr_pkg::icr_state_t s;
    icr_pkg::icr_state_t next_s;

    // Masked write on one of the four alias views
    function automatic logic [31:0] icr_apply(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [31:0] mask,
        input logic [1:0] op
    );
        logic [31:0] m;
        m = wd & mask;
        case (op)
            icr_pkg::OP_BASE: icr_apply = (old & ~mask) | m;
            icr_pkg::OP_CLR: icr_apply = old & ~m;
            icr_pkg::OP_SET: icr_apply = old | m;
            default: icr_apply = old ^ m;
        endcase
    endfunction

    // Group index of a base offset
    function automatic logic [5:0] icr_grp(input logic [9:0] off);
        icr_grp = off[9:icr_pkg::GROUP_LSB];
    endfunction

    // Working variables of the combinational process
    logic frozen;
    logic addr_take;
    logic [5:0] grp;
    logic [1:0] op;
    logic [31:0] word;
    logic [31:0] rd;
    logic [icr_pkg::NUM_SRC-1:0] hw_set;
    logic [icr_pkg::NUM_SRC-1:0] new_set;
    logic [icr_pkg::NUM_EXT-1:0] edge_hit;
    logic [4:0] best_key;
    logic [4:0] key;
    logic [5:0] best_vec;
    logic best_found;
    logic qualify;
    logic [2:0] thr;
    logic [4:0] p;

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;
        frozen = 1'b0;
        addr_take = 1'b0;
        grp = 6'h00;
        op = 2'h0;
        word = 32'h0000_0000;
        rd = 32'h0000_0000;
        hw_set = '0;
        new_set = '0;
        edge_hit = '0;
        best_key = 5'h00;
        key = 5'h00;
        best_vec = 6'h00;
        best_found = 1'b0;
        qualify = 1'b0;
        thr = 3'h0;
        p = 5'h00;

        // Freeze only while the core sits in debug and halt is set
        frozen = s.control[icr_pkg::BIT_HALT] & debug_mode;

        // Pin synchroniser, first stage feeds only the second
        next_s.sync1 = ext_pin;
        next_s.sync2 = s.sync1;
        next_s.pin_prev = s.sync2;

        // Edge per pin, polarity picks rising or falling
        for (int k = 0; k < icr_pkg::NUM_EXT; k++) begin
            if (s.control[icr_pkg::POL_LSB + k]) begin
                edge_hit[k] = s.sync2[k] & ~s.pin_prev[k];
            end else begin
                edge_hit[k] = ~s.sync2[k] & s.pin_prev[k];
            end
        end

        // Hardware requests; frozen controller captures none
        if (!frozen) begin
            hw_set = src_event;
            for (int k = 0; k < icr_pkg::NUM_EXT; k++) begin
                hw_set[EXT_SRC_BASE + k] = src_event[EXT_SRC_BASE + k]
                                           | edge_hit[k];
            end
        end

        // Data phase of a write: apply through the alias view
        grp = s.dp_addr[icr_pkg::ADDR_W-1:icr_pkg::GROUP_LSB];
        op = s.dp_addr[3:2];
        if (s.dp_write) begin
            if (grp == icr_grp(icr_pkg::OFF_CONTROL)) begin
                next_s.control = icr_apply(s.control, hwdata,
                                           icr_pkg::CTRL_MASK, op);
                if (!debug_mode) begin
                    // Halt write outside debug has no effect
                    next_s.control[icr_pkg::BIT_HALT] =
                        s.control[icr_pkg::BIT_HALT];
                end
            end else if (grp == icr_grp(icr_pkg::OFF_RELOAD)) begin
                next_s.reload = icr_apply(s.reload, hwdata,
                                          icr_pkg::WORD_ONES, op);
            end
            for (int w = 0; w < icr_pkg::SRC_WORDS; w++) begin
                if (grp == icr_grp(icr_pkg::OFF_PENDING) + 6'(w)) begin
                    next_s.pending[w*32 +: 32] = icr_apply(
                        s.pending[w*32 +: 32], hwdata,
                        icr_pkg::WORD_ONES, op);
                end
                if (grp == icr_grp(icr_pkg::OFF_ENABLE) + 6'(w)) begin
                    next_s.enable[w*32 +: 32] = icr_apply(
                        s.enable[w*32 +: 32], hwdata,
                        icr_pkg::WORD_ONES, op);
                end
            end
            for (int w = 0; w < icr_pkg::PRIO_WORDS; w++) begin
                if (grp == icr_grp(icr_pkg::OFF_PRIO) + 6'(w)) begin
                    word = 32'h0000_0000;
                    for (int j = 0; j < icr_pkg::VEC_PER_WORD; j++) begin
                        word[j*icr_pkg::PRIO_STRIDE +: 5] =
                            s.prio[w*icr_pkg::VEC_PER_WORD + j];
                    end
                    word = icr_apply(word, hwdata, icr_pkg::PRIO_MASK, op);
                    for (int j = 0; j < icr_pkg::VEC_PER_WORD; j++) begin
                        next_s.prio[w*icr_pkg::VEC_PER_WORD + j] =
                            word[j*icr_pkg::PRIO_STRIDE +: 5];
                    end
                end
            end
        end

        // Halt bit held at zero outside debug
        if (!debug_mode) begin
            next_s.control[icr_pkg::BIT_HALT] = 1'b0;
        end

        // Hardware set wins over a same-cycle software clear
        next_s.pending = next_s.pending | hw_set;

        // Proximity timer: a fresh qualifying request reloads it
        new_set = next_s.pending & ~s.pending;
        thr = s.control[icr_pkg::THR_LSB +: 3];
        for (int i = 0; i < icr_pkg::NUM_SRC; i++) begin
            p = s.prio[i % icr_pkg::NUM_VEC];
            if (new_set[i] && s.enable[i] && p[4:2] != icr_pkg::LVL_OFF
                && p[4:2] <= thr) begin
                qualify = 1'b1;
            end
        end
        if (thr == icr_pkg::THR_OFF) begin
            qualify = 1'b0;
        end
        if (!frozen) begin
            if (qualify) begin
                next_s.timer = s.reload;
            end else if (s.timer != 32'h0000_0000) begin
                next_s.timer = s.timer - 32'h0000_0001;
            end
        end
        next_s.prox_busy = (next_s.timer != 32'h0000_0000);

        // Ranking over pending enabled sources; strict compare keeps
        // the lowest source index on equal keys
        for (int i = 0; i < icr_pkg::NUM_SRC; i++) begin
            key = s.prio[i % icr_pkg::NUM_VEC];
            if (s.pending[i] && s.enable[i]
                && key[4:2] != icr_pkg::LVL_OFF
                && (!best_found || key > best_key)) begin
                best_found = 1'b1;
                best_key = key;
                best_vec = 6'(i % icr_pkg::NUM_VEC);
            end
        end
        // Offer held still while frozen
        if (!frozen) begin
            next_s.offer.req = best_found;
            next_s.offer.level = best_found ? best_key[4:2] : 3'h0;
            next_s.offer.vector = best_vec;
        end
        next_s.multi = s.control[icr_pkg::BIT_MULTI];

        // Address phase: latch a transfer for its data phase
        addr_take = hsel && htrans == icr_pkg::HTRANS_NONSEQ && hready;
        next_s.dp_write = addr_take && hwrite;
        next_s.dp_addr = haddr[icr_pkg::ADDR_W-1:0];
        next_s.hready = 1'b1;

        // Read mux on post-write values so a write then read agrees
        grp = haddr[icr_pkg::ADDR_W-1:icr_pkg::GROUP_LSB];
        rd = 32'h0000_0000;
        if (haddr[3:2] != icr_pkg::OP_BASE) begin
            // Alias views read as zero
            rd = 32'h0000_0000;
        end else if (grp == icr_grp(icr_pkg::OFF_CONTROL)) begin
            rd = next_s.control & icr_pkg::CTRL_MASK;
        end else if (grp == icr_grp(icr_pkg::OFF_STATUS)) begin
            rd[icr_pkg::VEC_LSB +: 6] = s.offer.vector;
            rd[icr_pkg::LVL_LSB +: 3] = s.offer.level;
        end else if (grp == icr_grp(icr_pkg::OFF_RELOAD)) begin
            rd = next_s.reload;
        end else begin
            for (int w = 0; w < icr_pkg::SRC_WORDS; w++) begin
                if (grp == icr_grp(icr_pkg::OFF_PENDING) + 6'(w)) begin
                    rd = next_s.pending[w*32 +: 32];
                end
                if (grp == icr_grp(icr_pkg::OFF_ENABLE) + 6'(w)) begin
                    rd = next_s.enable[w*32 +: 32];
                end
            end
            for (int w = 0; w < icr_pkg::PRIO_WORDS; w++) begin
                if (grp == icr_grp(icr_pkg::OFF_PRIO) + 6'(w)) begin
                    for (int j = 0; j < icr_pkg::VEC_PER_WORD; j++) begin
                        rd[j*icr_pkg::PRIO_STRIDE +: 5] =
                            next_s.prio[w*icr_pkg::VEC_PER_WORD + j];
                    end
                end
            end
        end
        // Unmapped address and non-read transfers give zero
        next_s.hrdata = (addr_take && !hwrite) ? rd : 32'h0000_0000;
    end

    // State register, constants only under reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.hready <= 1'b1;
            s.control <= icr_pkg::CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops, hresp tied to zero
    assign hrdata = s.hrdata;
    assign hreadyout = s.hready;
    assign hresp = 1'b0;
    assign irq_req = s.offer.req;
    assign irq_level = s.offer.level;
    assign irq_vector = s.offer.vector;
    assign irq_multi = s.multi;
    assign prox_busy = s.prox_busy;

endmodule // icr_top

// ---- sim/icr_core_model.sv ----
// Core model: enters debug on command and takes the offered vector.
// Assumes the offer struct of icr_pkg and the hclk domain.
`timescale 1ns/10ps
module icr_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic want_debug,
    input wire icr_pkg::icr_offer_t offer,
    output logic debug_mode,
    output icr_pkg::icr_offer_t taken
);
    // Debug entry lags the command by one edge, like a trap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            debug_mode <= 1'b0;
            taken <= '0;
        end else begin
            debug_mode <= want_debug;
            // Latch whatever is offered; last one wins
            if (offer.req) begin
                taken <= offer;
            end
        end
    end
endmodule // icr_core_model

// ---- sim/icr_props.sv ----
// Checker for the bus and offer ports of icr_top.
// Assumes the single hclk domain; bound to every icr_top below.
`timescale 1ns/10ps
module icr_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic irq_req,
    input wire logic [2:0] irq_level,
    input wire logic [5:0] irq_vector,
    input wire logic irq_multi,
    input wire logic prox_busy
);
    // Address phases accepted at this edge
    logic take;
    logic rd_take;
    logic ctl_wr;
    assign take = hsel && hready && htrans == icr_pkg::HTRANS_NONSEQ;
    assign rd_take = take && !hwrite;
    assign ctl_wr = take && hwrite && haddr[9:0] == 10'h000;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Status read: base word only, aliases excluded
    sequence st_rd;
        rd_take && haddr[9:0] == 10'h010;
    endsequence
    a_status_vector: assert property (
        st_rd |=> hrdata[5:0] == $past(irq_vector))
        else $error("status vector differs from offer");
    a_status_level: assert property (
        st_rd |=> hrdata[10:8] == $past(irq_level))
        else $error("status level differs from offer");
    a_status_spare: assert property (
        st_rd |=> hrdata[31:11] == '0 && hrdata[7:6] == '0)
        else $error("status spare bits not zero");
    a_alias_read: assert property (
        rd_take && haddr[3:2] != 2'h0 |=> hrdata == 32'h0)
        else $error("alias read not zero");
    a_unmapped_read: assert property (
        rd_take && haddr[9:0] >= 10'h190 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_rdata: assert property (
        !rd_take |=> hrdata == 32'h0)
        else $error("read data outside a read");
    a_req_level: assert property (
        irq_req |-> irq_level != 3'h0)
        else $error("offer with level zero");
    a_idle_level: assert property (
        !irq_req |-> irq_level == 3'h0)
        else $error("level shown with no offer");
    // Register lands one edge after data, mode copy one edge later
    a_multi_follow: assert property (
        ctl_wr |-> ##3 irq_multi == $past(hwdata[12], 2))
        else $error("mode copy wrong after write");
    c_status_read: cover property (st_rd);
    c_irq_rise: cover property ($rose(irq_req));
    c_prox_rise: cover property ($rose(prox_busy));
endmodule // icr_props

bind icr_top icr_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector(irq_vector), .irq_multi(irq_multi),
    .prox_busy(prox_busy)
);

// ---- sim/icr_top_tb.sv ----
// Self-checking bench for icr_top with a core model on the far side.
// Assumes hready is fed back from hreadyout, one slave on the bus.
`timescale 1ns/10ps
`define check_eq(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
        end \
    end
module icr_top_tb;
    // One row: write a word, read a word, expected read value
    typedef struct packed {
        logic [31:0] wa;
        logic [31:0] wd;
        logic [31:0] ra;
        logic [31:0] ex;
    } icr_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [95:0] src_event = 96'h0;
    logic [4:0] ext_pin = 5'h0;
    logic want_debug = 1'b0;
    logic debug_mode;
    logic prox_busy;
    // Separate nets per offer field, one driver each
    logic irq_req;
    logic [2:0] irq_level;
    logic [5:0] irq_vector;
    logic irq_multi;
    icr_pkg::icr_offer_t offer;
    icr_pkg::icr_offer_t taken;
    logic [31:0] r;
    int mismatches = 0;
    int checks_done = 0;
    // Proximity cases: setup write, expected busy
    logic [31:0] pa [3] = '{32'h14, 32'hA4, 32'h4};
    logic [31:0] pd [3] = '{32'h0, 32'h400, 32'h700};
    logic pe [3] = '{1'b0, 1'b1, 1'b0};
    icr_row_t rows [16] = '{
        '{32'h10, 32'hFFFFFFFF, 32'h0, 32'h0},
        '{32'h20, 32'h12345678, 32'h20, 32'h12345678},
        '{32'h24, 32'h0000FFFF, 32'h20, 32'h12340000},
        '{32'h28, 32'h0000000F, 32'h20, 32'h1234000F},
        '{32'h2C, 32'hFF00000F, 32'h20, 32'hED340000},
        '{32'h0, 32'hFFFFFFFF, 32'h0, 32'h0001171F},
        '{32'h4, 32'h0000071F, 32'h0, 32'h00011000},
        '{32'hC, 32'h00001000, 32'h0, 32'h00010000},
        '{32'h90, 32'hFFFFFFFF, 32'h90, 32'h1F1F1F1F},
        '{32'h94, 32'hFFFFFFFF, 32'h90, 32'h0},
        '{32'h10, 32'hFFFFFFFF, 32'h10, 32'h0},
        '{32'h38, 32'h00000001, 32'h30, 32'h1},
        '{32'h34, 32'h00000001, 32'h30, 32'h0},
        '{32'h68, 32'hFFFFFFFF, 32'h60, 32'hFFFFFFFF},
        '{32'h18, 32'h0, 32'h18, 32'h0},
        '{32'h190, 32'hFFFFFFFF, 32'h190, 32'h0}
    };
    always #50 hclk = ~hclk;
    icr_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .src_event(src_event), .ext_pin(ext_pin),
        .debug_mode(debug_mode), .irq_req(irq_req),
        .irq_level(irq_level), .irq_vector(irq_vector),
        .irq_multi(irq_multi), .prox_busy(prox_busy)
    );
    // Offer bundle for the core model, field order as the struct
    assign offer = {irq_req, irq_level, irq_vector};
    icr_core_model core (
        .hclk(hclk), .hresetn(hresetn), .want_debug(want_debug),
        .offer(offer), .debug_mode(debug_mode), .taken(taken)
    );
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Next edge with ready high, bounded so a hang ends the run
    task automatic edge_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    // One single word transfer; read data left in r
    task automatic xfer(input logic w, input logic [31:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        r = hrdata;
    endtask
    // One cycle event pulse on the chosen sources
    task automatic pulse(input logic [95:0] m);
        src_event <= m;
        @(posedge hclk);
        src_event <= 96'h0;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].wa, rows[i].wd);
            xfer(1'b0, rows[i].ra, 32'h0);
            `check_eq(r, rows[i].ex)
        end
        // Mode bit was inverted back to zero by the last control row
        repeat (2) @(posedge hclk);
        `check_eq(irq_multi, 1'b0)
        // Same level on vectors 5 and 9, sub decides
        xfer(1'b1, 32'hA0, 32'hD00);
        xfer(1'b1, 32'hB0, 32'hE00);
        pulse(96'h220);
        repeat (2) @(posedge hclk);
        `check_eq(offer.vector, 6'h09)
        `check_eq(offer.level, 3'h3)
        xfer(1'b0, 32'h10, 32'h0);
        `check_eq(r, 32'h309)
        // Level zero takes vector 9 out of the race
        xfer(1'b1, 32'hB4, 32'h1C00);
        repeat (3) @(posedge hclk);
        `check_eq(taken.vector, 6'h05)
        xfer(1'b1, 32'h20, 32'h5);
        xfer(1'b1, 32'h8, 32'h200);
        for (int t = 0; t < 3; t++) begin
            xfer(1'b1, pa[t], pd[t]);
            xfer(1'b1, 32'h34, 32'hFFFFFFFF);
            pulse(96'h20);
            repeat (3) @(posedge hclk);
            `check_eq(prox_busy, pe[t])
            repeat (8) @(posedge hclk);
            `check_eq(prox_busy, 1'b0)
        end
        // Pin 0: no edge while the level is held, chosen edge caught, rising then falling
        xfer(1'b1, 32'h34, 32'hFFFFFFFF);
        for (int p = 1; p >= 0; p--) begin
            xfer(1'b1, p ? 32'h8 : 32'h4, 32'h1);
            ext_pin[0] <= !p;
            repeat (6) @(posedge hclk);
            xfer(1'b0, 32'h30, 32'h0);
            `check_eq(r, 32'h0)
            ext_pin[0] <= p[0];
            repeat (6) @(posedge hclk);
            xfer(1'b0, 32'h30, 32'h0);
            `check_eq(r, 32'h1)
            xfer(1'b1, 32'h34, 32'h1);
        end
        // Halt bit in debug: events are dropped while frozen
        want_debug <= 1'b1;
        repeat (2) @(posedge hclk);
        xfer(1'b1, 32'h8, 32'h4000);
        xfer(1'b0, 32'h0, 32'h0);
        `check_eq(r, 32'h14000)
        pulse(96'h20);
        repeat (2) @(posedge hclk);
        `check_eq(offer.req, 1'b0)
        want_debug <= 1'b0;
        repeat (2) @(posedge hclk);
        pulse(96'h20);
        repeat (2) @(posedge hclk);
        `check_eq(offer.level, 3'h2)
        xfer(1'b1, 32'h64, 32'h20);
        repeat (2) @(posedge hclk);
        `check_eq(offer.req, 1'b0)
        xfer(1'b0, 32'h0, 32'h0);
        `check_eq(r, 32'h10000)
        tally_and_finish();
    end
endmodule // icr_top_tb
